// *** common/base_ctrl_pkg.sv ***
package base_ctrl_pkg;
  // Time figures and derived cycle counts at 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int POLL_TIME_S = 7;
  localparam int POLL_CYCLES = POLL_TIME_S * CLK_HZ;
  localparam int DOCK_CHECK_S = 1;
  localparam int DOCK_CHECK_CYCLES = DOCK_CHECK_S * CLK_HZ;
  localparam int FRAME_TIME_US = 1400;
  localparam int FRAME_CYCLES = FRAME_TIME_US * (CLK_HZ / 1_000_000);
  localparam int HOOK_PULSE_MS = 200;
  localparam int HOOK_CYCLES = HOOK_PULSE_MS * (CLK_HZ / 1000);
  localparam int OOR_TIME_MS = 3000;
  localparam int OOR_CYCLES = OOR_TIME_MS * (CLK_HZ / 1000);
  localparam int LINK_TIMEOUT_MS = 10000;
  localparam int LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_MS * (CLK_HZ / 1000);
  // Standby listening intervals
  localparam int LISTEN_FAST_MS = 100;
  localparam int LISTEN_FAST_CYCLES = LISTEN_FAST_MS * (CLK_HZ / 1000);
  localparam int LISTEN_SLOW_MS = 2000;
  localparam int LISTEN_SLOW_CYCLES = LISTEN_SLOW_MS * (CLK_HZ / 1000);
  localparam int IDLE_LONG_S = 60;
  localparam int IDLE_LONG_CYCLES = IDLE_LONG_S * CLK_HZ;
  localparam int LISTEN_WINDOW_CYCLES = 1000;
  // Front-end
  localparam int NUM_COILS = 3;
  localparam int NUM_CAPS = 7;
  localparam int CAP_W = 8;
  localparam int RSSI_W = 8;
  // Firmware memory
  localparam int EEPROM_BITS = 16384;
  localparam int EEPROM_BYTES = EEPROM_BITS / 8;
  localparam int RAM_BYTES = 5120;
  localparam int ADDR_W = 13;
  localparam int CAP_TABLE_BASE = 0;
  localparam int CHG_RESET = 0;
  localparam logic [CAP_W-1:0] CAP_RESET = 8'h00;
  localparam logic [1:0] COIL_RESET = 2'h0;
  typedef enum logic [4:0] {
    MODE_STANDBY = 5'h01,
    MODE_ACQUIRE = 5'h02,
    MODE_LINKED = 5'h04,
    MODE_AIRLINE = 5'h08,
    MODE_CHARGE = 5'h10
  } mode_t;
endpackage

// *** rtl/fw_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
// Copies the external EEPROM image into internal RAM after reset, and
// passes write requests from the serial fixture through to the EEPROM once the copy is done.
module fw_loader #(
  parameter int DEPTH = base_ctrl_pkg::EEPROM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  output logic [base_ctrl_pkg::ADDR_W-1:0] ee_addr,
  output logic ee_rd,
  input wire logic ee_valid,
  input wire logic [7:0] ee_rdata,
  input wire logic prog_we,
  input wire logic [base_ctrl_pkg::ADDR_W-1:0] prog_addr,
  input wire logic [7:0] prog_data,
  output logic ee_wr,
  output logic [7:0] ee_wdata,
  output logic ram_we,
  output logic [base_ctrl_pkg::ADDR_W-1:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic done
);
  localparam logic [base_ctrl_pkg::ADDR_W-1:0] LAST = base_ctrl_pkg::ADDR_W'(DEPTH - 1);
  logic [base_ctrl_pkg::ADDR_W-1:0] addr_q;
  logic done_q;
  logic [base_ctrl_pkg::ADDR_W-1:0] wr_addr_q;

  // Sequential read, one byte per accepted answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q && ee_valid) begin
      if (addr_q == LAST) begin
        done_q <= 1'b1;
      end
      addr_q <= addr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= 8'h00;
    end else begin
      ram_we <= !done_q && ee_valid;
      ram_addr <= addr_q;
      ram_wdata <= ee_rdata;
    end
  end

  // Reprogramming only after boot so the copy is not corrupted
  // Address is latched with the data so the fixture may move on at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ee_wr <= 1'b0;
      ee_wdata <= 8'h00;
      wr_addr_q <= '0;
    end else begin
      ee_wr <= done_q && prog_we;
      ee_wdata <= prog_data;
      wr_addr_q <= prog_addr;
    end
  end

  assign ee_rd = !done_q;
  assign ee_addr = done_q ? wr_addr_q : addr_q;
  assign done = done_q;
endmodule
`default_nettype wire

// *** rtl/headset_base_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module headset_base_ctrl #(
  parameter int POLL_CYCLES = base_ctrl_pkg::POLL_CYCLES,
  parameter int DOCK_CHECK_CYCLES = base_ctrl_pkg::DOCK_CHECK_CYCLES,
  parameter int FRAME_CYCLES = base_ctrl_pkg::FRAME_CYCLES,
  parameter int HOOK_CYCLES = base_ctrl_pkg::HOOK_CYCLES,
  parameter int OOR_CYCLES = base_ctrl_pkg::OOR_CYCLES,
  parameter int LINK_TIMEOUT_CYCLES = base_ctrl_pkg::LINK_TIMEOUT_CYCLES,
  parameter int LISTEN_FAST_CYCLES = base_ctrl_pkg::LISTEN_FAST_CYCLES,
  parameter int LISTEN_SLOW_CYCLES = base_ctrl_pkg::LISTEN_SLOW_CYCLES,
  parameter int IDLE_LONG_CYCLES = base_ctrl_pkg::IDLE_LONG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [base_ctrl_pkg::RSSI_W-1:0] rssi_x,
  input wire logic [base_ctrl_pkg::RSSI_W-1:0] rssi_y,
  input wire logic [base_ctrl_pkg::RSSI_W-1:0] rssi_z,
  input wire logic [2:0] cap_level,
  output logic [1:0] coil_sel,
  output logic tx_active,
  output logic tr_switch_closed,
  output logic tx_drive_en,
  output logic [base_ctrl_pkg::CAP_W-1:0] rx_cap,
  output logic tx_channel2,
  output logic rx_channel2,
  input wire logic channel2_sel,
  output logic [base_ctrl_pkg::ADDR_W-1:0] ee_addr,
  output logic ee_rd,
  input wire logic ee_valid,
  input wire logic [7:0] ee_rdata,
  output logic ee_wr,
  output logic [7:0] ee_wdata,
  input wire logic prog_we,
  input wire logic [base_ctrl_pkg::ADDR_W-1:0] prog_addr,
  input wire logic [7:0] prog_data,
  output logic boot_done,
  input wire logic page_rx,
  input wire logic link_ok,
  input wire logic partner_present,
  input wire logic critical_shutdown,
  input wire logic dock_pin,
  input wire logic airline_cmd,
  input wire logic charge_cmd,
  input wire logic housekeeping,
  input wire logic call_button,
  input wire logic call_alert_pin,
  input wire logic charge_enable,
  output logic page_tx,
  output logic charge_line,
  output logic listen,
  output logic dock_check,
  output logic answer_call,
  output logic hook_signal_line,
  output logic phone_aud_in_pull_low,
  output logic [4:0] mode
);
  localparam int FW = 32;
  base_ctrl_pkg::mode_t mode_q;
  logic [1:0] dock_sync_q, alert_sync_q, btn_sync_q;
  logic docked, alert, btn, btn_prev_q, press, alert_prev_q, alert_rise;
  logic undocked_edge, dock_prev_q;
  logic [FW-1:0] frame_cnt_q, poll_cnt_q, dock_cnt_q, hook_cnt_q, oor_cnt_q;
  logic [FW-1:0] idle_cnt_q, listen_cnt_q, link_cnt_q;
  logic tx_frame_q, incoming_q, in_call_q, fresh_undock_q, hook_q;
  logic ram_we;
  logic [base_ctrl_pkg::ADDR_W-1:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] fw_ram [base_ctrl_pkg::RAM_BYTES];
  logic [base_ctrl_pkg::CAP_W-1:0] cap_table [base_ctrl_pkg::NUM_CAPS];
  logic [FW-1:0] listen_period;

  // Dock, call alert and call button pins pass two flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dock_sync_q <= 2'h0;
      alert_sync_q <= 2'h0;
      btn_sync_q <= 2'h0;
    end else begin
      dock_sync_q <= {dock_sync_q[0], dock_pin};
      alert_sync_q <= {alert_sync_q[0], call_alert_pin};
      btn_sync_q <= {btn_sync_q[0], call_button};
    end
  end
  assign docked = dock_sync_q[1];
  assign alert = alert_sync_q[1];
  assign btn = btn_sync_q[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_prev_q <= 1'b0;
      alert_prev_q <= 1'b0;
      dock_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= btn;
      alert_prev_q <= alert;
      dock_prev_q <= docked;
    end
  end
  assign press = btn && !btn_prev_q;
  assign alert_rise = alert && !alert_prev_q;
  assign undocked_edge = dock_prev_q && !docked;

  fw_loader #(
    .DEPTH(base_ctrl_pkg::EEPROM_BYTES)
  ) u_loader (
    .clk(clk),
    .rst(rst),
    .ee_addr(ee_addr),
    .ee_rd(ee_rd),
    .ee_valid(ee_valid),
    .ee_rdata(ee_rdata),
    .prog_we(prog_we),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .ee_wr(ee_wr),
    .ee_wdata(ee_wdata),
    .ram_we(ram_we),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .done(boot_done)
  );

  always_ff @(posedge clk) begin
    if (ram_we && ram_addr < base_ctrl_pkg::ADDR_W'(base_ctrl_pkg::RAM_BYTES)) begin
      fw_ram[ram_addr] <= ram_wdata;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < base_ctrl_pkg::NUM_CAPS; gi++) begin : g_cap
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cap_table[gi] <= base_ctrl_pkg::CAP_RESET;
        end else if (ram_we &&
                     ram_addr == base_ctrl_pkg::ADDR_W'(base_ctrl_pkg::CAP_TABLE_BASE + gi)) begin
          cap_table[gi] <= ram_wdata;
        end
      end
    end
  endgenerate

  // best coil choice, ties favour lower axis
  function automatic logic [1:0] best_coil(input logic [base_ctrl_pkg::RSSI_W-1:0] a,
                                           input logic [base_ctrl_pkg::RSSI_W-1:0] b,
                                           input logic [base_ctrl_pkg::RSSI_W-1:0] c);
    logic [1:0] r;
    r = 2'h0;
    if (b > a && b >= c) begin
      r = 2'h1;
    end else if (c > a && c > b) begin
      r = 2'h2;
    end
    return r;
  endfunction

  // reselect on every cycle of a receive frame only, so a transmit frame never switches mid-burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coil_sel <= base_ctrl_pkg::COIL_RESET;
    end else if (!tx_frame_q) begin
      coil_sel <= best_coil(rssi_x, rssi_y, rssi_z);
    end
  end

  // TDD frame timing, radio idle in airline mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_cnt_q <= '0;
      tx_frame_q <= 1'b0;
    end else if (frame_cnt_q >= FW'(FRAME_CYCLES - 1)) begin
      frame_cnt_q <= '0;
      tx_frame_q <= !tx_frame_q;
    end else begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
    end
  end

  logic radio_on;
  assign radio_on = boot_done && (mode_q == base_ctrl_pkg::MODE_ACQUIRE ||
                                  mode_q == base_ctrl_pkg::MODE_LINKED || listen);

  // transmit frame drive, receive frame float, radio silent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_active <= 1'b0;
      tx_drive_en <= 1'b0;
      tr_switch_closed <= 1'b1;
      rx_cap <= base_ctrl_pkg::CAP_RESET;
    end else begin
      tx_active <= radio_on && tx_frame_q && !listen;
      tx_drive_en <= radio_on && tx_frame_q && !listen;
      tr_switch_closed <= !(radio_on && tx_frame_q && !listen);
      if (!tx_frame_q && cap_level < 3'(base_ctrl_pkg::NUM_CAPS)) begin
        rx_cap <= cap_table[cap_level];
      end
    end
  end

  // transmit tuning fixed to channel one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_channel2 <= 1'b0;
      rx_channel2 <= 1'b0;
    end else begin
      tx_channel2 <= 1'b0;
      rx_channel2 <= channel2_sel;
    end
  end

  // idle time and fresh undock choose listen interval
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_q <= '0;
      fresh_undock_q <= 1'b0;
    end else begin
      if (mode_q != base_ctrl_pkg::MODE_STANDBY) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q < FW'(IDLE_LONG_CYCLES)) begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
      if (undocked_edge) begin
        fresh_undock_q <= 1'b1;
      end else if (mode_q != base_ctrl_pkg::MODE_STANDBY ||
                   idle_cnt_q >= FW'(IDLE_LONG_CYCLES)) begin
        fresh_undock_q <= 1'b0;
      end
    end
  end
  assign listen_period = (fresh_undock_q || idle_cnt_q < FW'(IDLE_LONG_CYCLES)) ?
                         FW'(LISTEN_FAST_CYCLES) : FW'(LISTEN_SLOW_CYCLES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      listen_cnt_q <= '0;
    end else if (mode_q != base_ctrl_pkg::MODE_STANDBY || docked ||
                 listen_cnt_q >= listen_period - 1) begin
      listen_cnt_q <= '0;
    end else begin
      listen_cnt_q <= listen_cnt_q + 1'b1;
    end
  end
  assign listen = (mode_q == base_ctrl_pkg::MODE_STANDBY) && !docked && boot_done &&
                  listen_cnt_q < FW'(base_ctrl_pkg::LISTEN_WINDOW_CYCLES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dock_cnt_q <= '0;
      dock_check <= 1'b0;
    end else if (!docked || dock_cnt_q >= FW'(DOCK_CHECK_CYCLES - 1)) begin
      dock_cnt_q <= '0;
      dock_check <= docked;
    end else begin
      dock_cnt_q <= dock_cnt_q + 1'b1;
      dock_check <= 1'b0;
    end
  end

  // seven-second acquire poll, out-of-range and link timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poll_cnt_q <= '0;
      oor_cnt_q <= '0;
      link_cnt_q <= '0;
    end else begin
      poll_cnt_q <= (mode_q == base_ctrl_pkg::MODE_ACQUIRE) ? poll_cnt_q + 1'b1 : '0;
      oor_cnt_q <= (mode_q == base_ctrl_pkg::MODE_LINKED && !partner_present) ?
                   oor_cnt_q + 1'b1 : '0;
      link_cnt_q <= (mode_q == base_ctrl_pkg::MODE_LINKED && !link_ok) ?
                    link_cnt_q + 1'b1 : '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= base_ctrl_pkg::MODE_STANDBY;
    end else if (boot_done) begin
      unique case (mode_q)
        base_ctrl_pkg::MODE_STANDBY: begin
          if (docked && dock_check && airline_cmd) begin
            mode_q <= base_ctrl_pkg::MODE_AIRLINE;
          end else if (docked && dock_check && charge_cmd) begin
            mode_q <= base_ctrl_pkg::MODE_CHARGE;
          end else if (!docked && ((listen && page_rx) || alert_rise || press)) begin
            mode_q <= base_ctrl_pkg::MODE_ACQUIRE;
          end
        end
        base_ctrl_pkg::MODE_ACQUIRE: begin
          if (docked) begin
            mode_q <= base_ctrl_pkg::MODE_STANDBY;
          end else if (link_ok) begin
            mode_q <= base_ctrl_pkg::MODE_LINKED;
          end else if (poll_cnt_q >= FW'(POLL_CYCLES - 1)) begin
            mode_q <= base_ctrl_pkg::MODE_STANDBY;
          end
        end
        base_ctrl_pkg::MODE_LINKED: begin
          if (docked || critical_shutdown || oor_cnt_q >= FW'(OOR_CYCLES - 1) ||
              link_cnt_q >= FW'(LINK_TIMEOUT_CYCLES - 1)) begin
            mode_q <= base_ctrl_pkg::MODE_STANDBY;
          end
        end
        base_ctrl_pkg::MODE_AIRLINE: begin
          if (!docked) begin
            mode_q <= base_ctrl_pkg::MODE_STANDBY;
          end
        end
        base_ctrl_pkg::MODE_CHARGE: begin
          if (!docked) begin
            mode_q <= base_ctrl_pkg::MODE_STANDBY;
          end else if (dock_check && airline_cmd) begin
            mode_q <= base_ctrl_pkg::MODE_AIRLINE;
          end
        end
        default: begin
          mode_q <= base_ctrl_pkg::MODE_STANDBY;
        end
      endcase
    end
  end
  assign mode = mode_q;
  assign page_tx = mode_q == base_ctrl_pkg::MODE_ACQUIRE;

  // firmware charge line, paused for housekeeping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      charge_line <= 1'(base_ctrl_pkg::CHG_RESET);
    end else begin
      charge_line <= docked && charge_enable && !housekeeping &&
                     mode_q == base_ctrl_pkg::MODE_CHARGE;
    end
  end

  // remember incoming call, answer on press, hang-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      incoming_q <= 1'b0;
      in_call_q <= 1'b0;
      answer_call <= 1'b0;
      hook_q <= 1'b0;
    end else begin
      answer_call <= 1'b0;
      hook_q <= 1'b0;
      if (mode_q == base_ctrl_pkg::MODE_STANDBY && alert_rise) begin
        incoming_q <= 1'b1;
      end else if (mode_q != base_ctrl_pkg::MODE_LINKED &&
                   mode_q != base_ctrl_pkg::MODE_ACQUIRE) begin
        incoming_q <= 1'b0;
        in_call_q <= 1'b0;
      end
      if (mode_q == base_ctrl_pkg::MODE_LINKED && press) begin
        if (incoming_q && !in_call_q) begin
          answer_call <= 1'b1;
          in_call_q <= 1'b1;
          incoming_q <= 1'b0;
        end else if (in_call_q || !incoming_q) begin
          hook_q <= in_call_q;
          in_call_q <= !in_call_q;
        end
      end
    end
  end

  // hold hook signalling for a fixed pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hook_cnt_q <= '0;
    end else if (hook_q) begin
      hook_cnt_q <= FW'(HOOK_CYCLES);
    end else if (hook_cnt_q != '0) begin
      hook_cnt_q <= hook_cnt_q - 1'b1;
    end
  end
  assign hook_signal_line = hook_cnt_q != '0;
  assign phone_aud_in_pull_low = hook_cnt_q != '0;
endmodule
`default_nettype wire

// *** bench/base_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module base_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_active,
  input wire logic tr_switch_closed,
  input wire logic tx_drive_en,
  input wire logic tx_channel2,
  input wire logic rx_channel2,
  input wire logic channel2_sel,
  input wire logic ee_rd,
  input wire logic ee_wr,
  input wire logic [7:0] ee_wdata,
  input wire logic prog_we,
  input wire logic [7:0] prog_data,
  input wire logic boot_done,
  input wire logic call_alert_pin,
  input wire logic dock_pin,
  input wire logic listen,
  input wire logic dock_check,
  input wire logic answer_call,
  input wire logic hook_signal_line,
  input wire logic phone_aud_in_pull_low,
  input wire logic [4:0] mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence alert_in_standby;
    boot_done && !dock_pin && mode == base_ctrl_pkg::MODE_STANDBY ##1 $rose(call_alert_pin);
  endsequence
  sequence prog_taken;
    boot_done && prog_we;
  endsequence
  sequence ee_written;
    ee_wr && ee_wdata == $past(prog_data);
  endsequence
  one_mode_a: assert property ($onehot(mode)) else $error("mode not one-hot");
  tr_inverse_a: assert property (tr_switch_closed != tx_active && tx_drive_en == tx_active)
    else $error("t/r switch and driver disagree");
  tx_tuned_a: assert property (!tx_channel2) else $error("tx tuning left channel one");
  rx_tuned_a: assert property (!$past(rst) |-> rx_channel2 == $past(channel2_sel))
    else $error("rx tuning not following channel");
  alert_wake_a: assert property (alert_in_standby |-> ##[1:5] mode == base_ctrl_pkg::MODE_ACQUIRE)
    else $error("alert did not wake base");
  prog_write_a: assert property (prog_taken |=> ee_written) else $error("fixture write lost");
  prog_refused_a: assert property (prog_we && !boot_done |=> !ee_wr)
    else $error("write during boot");
  boot_frozen_a: assert property (!boot_done |-> ee_rd && mode == base_ctrl_pkg::MODE_STANDBY)
    else $error("mode moved before boot");
  hook_pair_a: assert property (hook_signal_line == phone_aud_in_pull_low)
    else $error("hook lines differ");
  answer_pulse_a: assert property (answer_call |=> !answer_call) else $error("answer too long");
  answer_mode_a: assert property (answer_call |-> mode == base_ctrl_pkg::MODE_LINKED)
    else $error("answer outside link");
  radio_quiet_a: assert property ((mode == base_ctrl_pkg::MODE_AIRLINE) [*2] |-> !tx_drive_en)
    else $error("transmit in airline");
  listen_mode_a: assert property (listen |-> mode == base_ctrl_pkg::MODE_STANDBY)
    else $error("listen outside standby");
  dock_pulse_a: assert property (dock_check |=> !dock_check) else $error("dock check too long");
endmodule
bind headset_base_ctrl base_ctrl_asserts u_chk (.clk, .rst, .tx_active, .tr_switch_closed,
  .tx_drive_en, .tx_channel2, .rx_channel2, .channel2_sel, .ee_rd, .ee_wr, .ee_wdata, .prog_we,
  .prog_data, .boot_done, .call_alert_pin, .dock_pin, .listen, .dock_check, .answer_call,
  .hook_signal_line, .phone_aud_in_pull_low, .mode);
`default_nettype wire

// *** bench/eeprom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
  parameter int GAP = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [base_ctrl_pkg::ADDR_W-1:0] ee_addr,
  input wire logic ee_rd,
  input wire logic ee_wr,
  input wire logic [7:0] ee_wdata,
  output logic ee_valid,
  output logic [7:0] ee_rdata
);
  logic [7:0] mem [0:2047];
  int gap_q;
  initial begin
    for (int a = 0; a < 2048; a++) begin
      mem[a] = a[7:0] ^ 8'h5A;
    end
  end
  always @(posedge clk) begin
    if (ee_wr) begin
      mem[ee_addr[10:0]] <= ee_wdata;
    end
  end
  // byte answers
  // Idle data is inverted each cycle so stale bytes never look valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= 0;
      ee_valid <= 1'h0;
      ee_rdata <= 8'hFF;
    end else if (ee_rd && !ee_valid && gap_q >= GAP) begin
      gap_q <= 0;
      ee_valid <= 1'h1;
      ee_rdata <= mem[ee_addr[10:0]];
    end else begin
      gap_q <= gap_q + 1;
      ee_valid <= 1'h0;
      ee_rdata <= ~ee_rdata;
    end
  end
endmodule
`default_nettype wire

// *** bench/headset_base_mode_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module headset_base_mode_control_test;
  localparam int P_POLL = 200;
  localparam int P_DOCK = 60;
  localparam int P_FRAME = 20;
  localparam int P_HOOK = 30;
  localparam int P_OOR = 80;
  logic clk, rst, tx_active, tr_switch_closed, tx_drive_en, tx_channel2, rx_channel2;
  logic [7:0] rssi_x, rssi_y, rssi_z, rx_cap, ee_rdata, ee_wdata, prog_data;
  logic [2:0] cap_level;
  logic [1:0] coil_sel;
  logic [4:0] mode;
  logic [12:0] ee_addr, prog_addr;
  logic channel2_sel, ee_rd, ee_valid, ee_wr, prog_we, boot_done, page_rx, link_ok;
  logic partner_present, critical_shutdown, dock_pin, airline_cmd, charge_cmd, housekeeping;
  logic call_button, call_alert_pin, charge_enable, page_tx, charge_line, listen, dock_check;
  logic answer_call, hook_signal_line, phone_aud_in_pull_low, hook_seen;
  int err_total, n_compared;
  headset_base_ctrl #(.POLL_CYCLES(P_POLL), .DOCK_CHECK_CYCLES(P_DOCK), .FRAME_CYCLES(P_FRAME),
    .HOOK_CYCLES(P_HOOK), .OOR_CYCLES(P_OOR), .LINK_TIMEOUT_CYCLES(2000),
    .LISTEN_FAST_CYCLES(1200), .LISTEN_SLOW_CYCLES(2400), .IDLE_LONG_CYCLES(3000)) dut (
    .clk, .rst, .rssi_x, .rssi_y, .rssi_z, .cap_level, .coil_sel, .tx_active,
    .tr_switch_closed, .tx_drive_en, .rx_cap, .tx_channel2, .rx_channel2, .channel2_sel,
    .ee_addr, .ee_rd, .ee_valid, .ee_rdata, .ee_wr, .ee_wdata, .prog_we, .prog_addr,
    .prog_data, .boot_done, .page_rx, .link_ok, .partner_present, .critical_shutdown,
    .dock_pin, .airline_cmd, .charge_cmd, .housekeeping, .call_button, .call_alert_pin,
    .charge_enable, .page_tx, .charge_line, .listen, .dock_check, .answer_call,
    .hook_signal_line, .phone_aud_in_pull_low, .mode);
  eeprom_model #(.GAP(1)) u_ee (.clk, .rst, .ee_addr, .ee_rd, .ee_wr, .ee_wdata, .ee_valid,
    .ee_rdata);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (hook_signal_line === 1'h1) hook_seen = 1'h1;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_mode(input logic [4:0] exp, input int max);
    int i;
    i = 0;
    while (mode !== exp && i < max) begin
      step(1);
      i++;
    end
    check("mode", {11'h000, exp}, {11'h000, mode});
  endtask
  task automatic press;
    call_button = 1'h1;
    step(4);
    call_button = 1'h0;
    step(4);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_boot;
    int i;
    i = 0;
    while (boot_done !== 1'h1 && i < 6000) begin
      step(1);
      i++;
    end
    prog_we = 1'h0;
    check("boot_done", 16'h0001, {15'h0000, boot_done});
    check("mode", 16'h0001, {11'h000, mode});
    step(2);
    prog_addr = 13'h0123;
    prog_data = 8'hA7;
    prog_we = 1'h1;
    step(1);
    prog_we = 1'h0;
    check("ee_wr", 16'h0001, {15'h0000, ee_wr});
    check("ee_wdata", 16'h00A7, {8'h00, ee_wdata});
    $display("test boot and fixture done");
  endtask
  task automatic t_incoming;
    int i, n, seen;
    call_alert_pin = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_ACQUIRE, 8);
    link_ok = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_LINKED, 8);
    seen = 0;
    call_button = 1'h1;
    for (i = 0; i < 10; i++) begin
      step(1);
      if (answer_call === 1'h1) seen = 1;
    end
    call_button = 1'h0;
    check("answer_call", 16'h0001, 16'(seen));
    call_alert_pin = 1'h0;
    step(4);
    call_button = 1'h1;
    i = 0;
    while (hook_signal_line !== 1'h1 && i < 12) begin
      step(1);
      i++;
    end
    call_button = 1'h0;
    n = 0;
    while (hook_signal_line === 1'h1 && n < P_HOOK + 10) begin
      step(1);
      n++;
    end
    check("hook_width_ok", 16'h0001, 16'(n >= P_HOOK && n <= P_HOOK + 2));
    $display("test incoming call done");
  endtask
  task automatic t_out_of_range;
    press();
    hook_seen = 1'h0;
    partner_present = 1'h0;
    wait_mode(base_ctrl_pkg::MODE_STANDBY, P_OOR + 20);
    check("hook_seen", 16'h0000, {15'h0000, hook_seen});
    partner_present = 1'h1;
    link_ok = 1'h0;
    step(4);
    call_alert_pin = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_ACQUIRE, 8);
    call_alert_pin = 1'h0;
    step(P_POLL - 20);
    check("mode", 16'h0002, {11'h000, mode});
    check("page_tx", 16'h0001, {15'h0000, page_tx});
    wait_mode(base_ctrl_pkg::MODE_STANDBY, 40);
    $display("test range and poll done");
  endtask
  task automatic t_outgoing;
    int n;
    press();
    wait_mode(base_ctrl_pkg::MODE_ACQUIRE, 8);
    link_ok = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_LINKED, 8);
    for (int k = 0; k < 7; k++) begin
      cap_level = k[2:0];
      step(2 * P_FRAME + 4);
      check("rx_cap", {8'h00, k[7:0] ^ 8'h5A}, {8'h00, rx_cap});
    end
    for (int k = 0; k < 3; k++) begin
      rssi_x = (k == 0) ? 8'hC0 : 8'h20;
      rssi_y = (k == 1) ? 8'hC0 : 8'h20;
      rssi_z = (k == 2) ? 8'hC0 : 8'h20;
      step(2 * P_FRAME + 4);
      check("coil_sel", 16'(k), {14'h0000, coil_sel});
    end
    n = 0;
    repeat (2 * P_FRAME) begin
      step(1);
      if (tx_active === 1'h1 && tr_switch_closed === 1'h0) n++;
    end
    check("tx_frames", 16'(P_FRAME), 16'(n));
    channel2_sel = 1'h1;
    step(2);
    check("rx_channel2", 16'h0001, {15'h0000, rx_channel2});
    channel2_sel = 1'h0;
    dock_pin = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_STANDBY, 10);
    link_ok = 1'h0;
    $display("test outgoing link done");
  endtask
  task automatic t_docked;
    int n;
    n = 0;
    repeat (2 * P_DOCK) begin
      step(1);
      if (dock_check === 1'h1) n++;
    end
    check("dock_checks", 16'h0002, 16'(n));
    airline_cmd = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_AIRLINE, P_DOCK + 10);
    airline_cmd = 1'h0;
    step(2 * P_FRAME);
    dock_pin = 1'h0;
    wait_mode(base_ctrl_pkg::MODE_STANDBY, 10);
    dock_pin = 1'h1;
    charge_cmd = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_CHARGE, P_DOCK + 10);
    charge_cmd = 1'h0;
    charge_enable = 1'h1;
    step(3);
    check("charge_line", 16'h0001, {15'h0000, charge_line});
    housekeeping = 1'h1;
    step(3);
    check("charge_line", 16'h0000, {15'h0000, charge_line});
    housekeeping = 1'h0;
    press();
    check("mode", 16'h0010, {11'h000, mode});
    dock_pin = 1'h0;
    charge_enable = 1'h0;
    wait_mode(base_ctrl_pkg::MODE_STANDBY, P_DOCK + 10);
    n = 0;
    repeat (1200) begin
      step(1);
      if (listen === 1'h1) n++;
    end
    check("listen_cycles", 16'h03E8, 16'(n));
    page_rx = 1'h1;
    wait_mode(base_ctrl_pkg::MODE_ACQUIRE, 1200);
    page_rx = 1'h0;
    $display("test docked and page done");
  endtask
  initial begin
    {page_rx, link_ok, critical_shutdown, dock_pin, airline_cmd, charge_cmd} = '0;
    {housekeeping, call_button, call_alert_pin, charge_enable, channel2_sel} = '0;
    {rssi_x, rssi_y, rssi_z, cap_level} = '0;
    partner_present = 1'h1;
    prog_addr = 13'h0005;
    prog_data = 8'h3C;
    prog_we = 1'h1;
    hook_seen = 1'h0;
    err_total = 0;
    n_compared = 0;
    rst = 1'h1;
    step(16);
    rst = 1'h0;
    t_boot();
    t_incoming();
    t_out_of_range();
    t_outgoing();
    t_docked();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("mismatch watchdog expected finish seen timeout");
    test_done();
  end
endmodule
`default_nettype wire
